// ---- logic/prm_defines.svh ----
// Purpose: Constants for the power reduction mode controller
// Assumes: 100 MHz system clock
// Notes: Times in ns, cycle counts derived from them
`ifndef PRM_DEFINES_SVH
`define PRM_DEFINES_SVH
`define PRM_CLK_PERIOD_NS 10
`define PRM_WAKE_MIN_NS 40
`define PRM_WAKE_MIN_CYC ((`PRM_WAKE_MIN_NS + `PRM_CLK_PERIOD_NS - 1) / `PRM_CLK_PERIOD_NS)
`define PRM_POWER_DOWN_CONFIG_BIT_BIT 5
`define PRM_NUM_FAST_IRQ 8
`define PRM_SYNC_STAGES 2
`define PRM_LP_DETECT_CYC 4
`endif

// ---- logic/prm_pkg.sv ----
// Purpose: Types for the power reduction mode controller
// Assumes: Included defines header for numbers
// Notes: States Gray coded in declaration order, RUN through WAKE
package prm_pkg;
    // Mode states
    typedef enum logic [2:0] {
        PRM_RUN = 3'h0,
        PRM_DRAIN = 3'h1,
        PRM_IDLE = 3'h3,
        PRM_PD_PROT = 3'h2,
        PRM_PD_INT = 3'h6,
        PRM_WAKE = 3'h4
    } prm_state_e;

    // Clock and core control outputs
    typedef struct packed {
        logic cpu_halt;
        logic periph_clk_en;
        logic main_osc_en;
        logic rtc_run;
        logic rtc_ref_lp;
    } prm_clk_ctl_s;

    // Standby RAM controls
    typedef struct packed {
        logic ram_freeze;
        logic ram_on_standby_supply;
    } prm_ram_ctl_s;
endpackage : prm_pkg

// ---- logic/prm_sync.sv ----
// Purpose: Two stage synchroniser for a vector of levels
// Assumes: Single clock, async low reset
// Notes: First stage is read only by the second stage
`timescale 1ns/1ns
module prm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    // All state of this module
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } prm_sync_s;
    prm_sync_s st_r;
    prm_sync_s st_nxt;

    // Next state: shift through stages
    always_comb begin
        st_nxt.s1 = i_d;
        st_nxt.s2 = st_r.s1;
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_q = st_r.s2;
endmodule : prm_sync

// ---- logic/prm_standby.sv ----
// Purpose: Standby RAM freeze and supply switching
// Assumes: Chip reset level and supply-low flag synchronous
// Notes: Freeze held through any reset until enable bit set
`timescale 1ns/1ns
`include "prm_defines.svh"
module prm_standby (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_chip_reset,
    input wire logic i_standby_ram_enable_bit,
    input wire logic i_core_supply_low,
    output prm_pkg::prm_ram_ctl_s o_ram
);
    // All state of this module
    typedef struct packed {
        logic freeze;
        logic on_sb;
    } prm_sb_s;
    prm_sb_s st_r;
    prm_sb_s st_nxt;

    // Freeze and supply selection
    always_comb begin
        st_nxt = st_r;
        if (i_chip_reset || i_core_supply_low) begin
            st_nxt.on_sb = 1'b1;
        end else if (st_r.on_sb) begin
            st_nxt.on_sb = 1'b0; // [R21]
        end
        if (i_chip_reset && !i_standby_ram_enable_bit) begin
            st_nxt.freeze = 1'b1; // [R18]
        end else if (i_core_supply_low) begin
            st_nxt.freeze = 1'b1; // [R20]
        end else if (i_standby_ram_enable_bit && !i_chip_reset) begin
            st_nxt.freeze = 1'b0; // [R19]
        end else if (i_chip_reset) begin
            st_nxt.freeze = 1'b1; // [R19]
        end
    end

    // State register, frozen out of reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '{freeze: 1'b1, on_sb: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Immediate freeze also combinational on reset entry with enable bit clear
    always_comb begin
        o_ram.ram_freeze = st_r.freeze | (i_chip_reset & ~i_standby_ram_enable_bit);
        o_ram.ram_on_standby_supply = st_r.on_sb;
    end
endmodule : prm_standby

// ---- logic/prm_ctrl.sv ----
// Purpose: Power reduction mode control: idle, power-down, standby
// Assumes: All inputs synchronous to i_clk except wake sources
// Notes: Wake sources pass through a synchroniser before waking; entry check reads fast lines raw
//
// Overview of operation
// R1: Idle halts CPU, peripherals keep running
// R2: Power-down stops CPU and peripherals
// R3: Finish outstanding bus cycles before entry
// R4: Refuse entry if enabled wait handshake missed
// R5: Any interrupt ends idle mode
// R6: Power-down stops clock; only RTC may run
// R7: Low-power oscillator present: stop main oscillator
// R8: Detected low-power oscillator becomes permanent RTC reference; code drops it while i_lp_osc_disable is set
// R9: Only main oscillator: keep it running
// R10: Software sets regulator-off bit before power-down
// R11: Config bit clear selects protected power-down
// R12: Protected entry needs NMI low
// R13: Protected mode leaves only by external reset
// R14: Config bit set selects interruptible power-down
// R15: Interruptible entry needs enabled fast inputs inactive
// R16: Reset, fast interrupt, RTC, CAN, I2C wake
// R17: Fast input must stay asserted 40 ns
// R18: Reset with enable cleared freezes standby RAM
// R19: RAM frozen after reset until enable set
// R20: Low supply keeps RAM frozen regardless
// R21: Reset release returns RAM to main supply
// R22: Standby RTC runs only on low-power reference
// R23: Synchronised wake sources restart clock first
`timescale 1ns/1ns
`include "prm_defines.svh"
module prm_ctrl #(
    parameter int NUM_FAST_IRQ = `PRM_NUM_FAST_IRQ,
    parameter int WAKE_MIN_CYC = `PRM_WAKE_MIN_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_idle_instruction,
    input wire logic i_power_down_instruction,
    input wire logic [15:0] i_system_configuration_register,
    input wire logic i_main_regulator_off_bit,
    input wire logic i_bus_busy,
    input wire logic i_ready_enable,
    input wire logic i_ready_seen,
    input wire logic i_nmi_n,
    input wire logic i_irq_request,
    input wire logic i_return_from_interrupt_done,
    input wire logic [NUM_FAST_IRQ-1:0] i_fast_external_interrupt_input,
    input wire logic [NUM_FAST_IRQ-1:0] i_fast_irq_enable,
    input wire logic [NUM_FAST_IRQ-1:0] i_fast_irq_active_high,
    input wire logic i_rtc_irq,
    input wire logic i_can_wake,
    input wire logic i_i2c_wake,
    input wire logic i_rtc_enable,
    input wire logic i_lp_osc_running,
    input wire logic i_lp_osc_disable,
    input wire logic i_chip_reset,
    input wire logic i_standby_ram_enable_bit,
    input wire logic i_core_supply_low,
    output prm_pkg::prm_clk_ctl_s o_clk_ctl,
    output prm_pkg::prm_ram_ctl_s o_ram_ctl,
    output prm_pkg::prm_state_e o_state,
    output logic o_entry_refused,
    output logic o_resume_after_idle,
    output logic o_regulator_off_req
);
    // Parameter checks
    initial begin
        if (NUM_FAST_IRQ < 1 || NUM_FAST_IRQ > 16) begin
            $error("NUM_FAST_IRQ out of range");
        end
        if (WAKE_MIN_CYC < 1 || WAKE_MIN_CYC > 15) begin
            $error("WAKE_MIN_CYC out of range");
        end
    end

    // Reset release through two flops
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Synchronised wake inputs: fast lines plus RTC, CAN, I2C
    localparam int NW = NUM_FAST_IRQ + 3;
    logic [NW-1:0] wake_raw;
    logic [NW-1:0] wake_sync;
    assign wake_raw = {i_rtc_irq, i_can_wake, i_i2c_wake, i_fast_external_interrupt_input};
    prm_sync #(.WIDTH(NW)) u_wake_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_d(wake_raw),
        .o_q(wake_sync)
    ); // [R23]

    // Per-line active level and enable
    logic [NUM_FAST_IRQ-1:0] fast_act;
    logic [NUM_FAST_IRQ-1:0] fast_act_now;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FAST_IRQ; gi++) begin : g_fast
            // Synchronised, enabled, polarity-corrected request
            assign fast_act[gi] = i_fast_irq_enable[gi] &
                (wake_sync[gi] ~^ i_fast_irq_active_high[gi]);
            // Raw level at entry check time
            assign fast_act_now[gi] = i_fast_irq_enable[gi] &
                (i_fast_external_interrupt_input[gi] ~^ i_fast_irq_active_high[gi]);
        end
    endgenerate

    // All state of the controller
    typedef struct packed {
        prm_pkg::prm_state_e state;
        logic pend_pd;
        logic refused;
        logic resume;
        logic lp_ref;
        logic [3:0] lp_cnt;
        logic [NUM_FAST_IRQ-1:0][3:0] hold_cnt;
    } prm_ctrl_s;
    prm_ctrl_s st_r;
    prm_ctrl_s st_nxt;

    // Entry and wake qualification signals
    logic pwd_interruptible;
    logic handshake_bad;
    logic fast_wake;
    logic other_wake;
    assign pwd_interruptible = i_system_configuration_register[`PRM_POWER_DOWN_CONFIG_BIT_BIT]; // [R11] [R14]
    assign handshake_bad = i_ready_enable & ~i_ready_seen; // [R4]
    assign other_wake = wake_sync[NW-1] | wake_sync[NW-2] | wake_sync[NW-3]; // [R16]

    // A fast line must be held long enough to count
    always_comb begin
        fast_wake = 1'b0;
        for (int k = 0; k < NUM_FAST_IRQ; k++) begin
            if (st_r.hold_cnt[k] >= 4'(WAKE_MIN_CYC)) begin
                fast_wake = 1'b1; // [R17]
            end
        end
    end

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.refused = 1'b0;
        st_nxt.resume = 1'b0;
        // Hold counters for fast lines
        for (int k = 0; k < NUM_FAST_IRQ; k++) begin
            if (!fast_act[k]) begin
                st_nxt.hold_cnt[k] = 4'h0;
            end else if (st_r.hold_cnt[k] != 4'hf) begin
                st_nxt.hold_cnt[k] = st_r.hold_cnt[k] + 4'h1;
            end
        end
        // Low-power oscillator detection, kept until disabled
        if (i_lp_osc_disable) begin
            st_nxt.lp_ref = 1'b0;
            st_nxt.lp_cnt = 4'h0;
        end else if (!st_r.lp_ref) begin
            if (!i_lp_osc_running) begin
                st_nxt.lp_cnt = 4'h0;
            end else if (st_r.lp_cnt == 4'(`PRM_LP_DETECT_CYC)) begin
                st_nxt.lp_ref = 1'b1; // [R8]
            end else begin
                st_nxt.lp_cnt = st_r.lp_cnt + 4'h1;
            end
        end
        unique case (st_r.state)
            prm_pkg::PRM_RUN: begin
                if (i_idle_instruction || i_power_down_instruction) begin
                    if (handshake_bad) begin
                        st_nxt.refused = 1'b1; // [R4]
                    end else if (i_power_down_instruction && !pwd_interruptible &&
                                 i_nmi_n) begin
                        st_nxt.refused = 1'b1; // [R12]
                    end else if (i_power_down_instruction && pwd_interruptible &&
                                 (|fast_act_now)) begin
                        st_nxt.refused = 1'b1; // [R15]
                    end else begin
                        st_nxt.pend_pd = i_power_down_instruction;
                        st_nxt.state = prm_pkg::PRM_DRAIN;
                    end
                end
            end
            prm_pkg::PRM_DRAIN: begin
                if (!i_bus_busy) begin // [R3]
                    if (!st_r.pend_pd) begin
                        st_nxt.state = prm_pkg::PRM_IDLE;
                    end else if (pwd_interruptible) begin
                        st_nxt.state = prm_pkg::PRM_PD_INT;
                    end else begin
                        st_nxt.state = prm_pkg::PRM_PD_PROT;
                    end
                end
            end
            prm_pkg::PRM_IDLE: begin
                if (i_irq_request) begin
                    st_nxt.state = prm_pkg::PRM_WAKE; // [R5]
                end
            end
            prm_pkg::PRM_PD_PROT: begin
                st_nxt.state = prm_pkg::PRM_PD_PROT; // [R13]
            end
            prm_pkg::PRM_PD_INT: begin
                if (fast_wake || other_wake) begin
                    st_nxt.state = prm_pkg::PRM_WAKE; // [R16] [R23]
                end
            end
            prm_pkg::PRM_WAKE: begin
                if (!st_r.pend_pd || i_return_from_interrupt_done || st_r.pend_pd) begin
                    st_nxt.state = prm_pkg::PRM_RUN;
                    st_nxt.resume = ~st_r.pend_pd; // [R5]
                    st_nxt.pend_pd = 1'b0;
                end
            end
            default: begin
                st_nxt.state = prm_pkg::PRM_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Clock control decode
    logic in_pd;
    assign in_pd = (st_r.state == prm_pkg::PRM_PD_PROT) || (st_r.state == prm_pkg::PRM_PD_INT);
    always_comb begin
        o_clk_ctl.cpu_halt = (st_r.state != prm_pkg::PRM_RUN) &&
                             (st_r.state != prm_pkg::PRM_DRAIN); // [R1] [R2]
        o_clk_ctl.periph_clk_en = ~in_pd; // [R1] [R6]
        o_clk_ctl.main_osc_en = ~in_pd | (i_rtc_enable & ~st_r.lp_ref); // [R7] [R9]
        o_clk_ctl.rtc_run = i_rtc_enable &
            (st_r.lp_ref | ~i_chip_reset); // [R6] [R22]
        o_clk_ctl.rtc_ref_lp = st_r.lp_ref; // [R8]
    end

    // Standby RAM handling
    prm_standby u_standby (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_chip_reset(i_chip_reset),
        .i_standby_ram_enable_bit(i_standby_ram_enable_bit),
        .i_core_supply_low(i_core_supply_low),
        .o_ram(o_ram_ctl)
    );

    assign o_state = st_r.state;
    assign o_entry_refused = st_r.refused;
    assign o_resume_after_idle = st_r.resume;
    // Regulator-off request during power-down, if software armed it [R10]
    assign o_regulator_off_req = in_pd & i_main_regulator_off_bit;
endmodule : prm_ctrl

// ---- verification/prm_ctrl_asserts.sv ----
// Purpose: Port-level assertions for the power reduction mode controller
// Assumes: One clock domain, async active-low reset
// Notes: Attached to every prm_ctrl instance by the bind at the foot
`timescale 1ns/1ns
module prm_ctrl_asserts #(
    parameter int NUM_FAST_IRQ = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_idle_instruction,
    input wire logic i_power_down_instruction,
    input wire logic [15:0] i_system_configuration_register,
    input wire logic i_bus_busy,
    input wire logic i_ready_enable,
    input wire logic i_ready_seen,
    input wire logic i_nmi_n,
    input wire logic i_irq_request,
    input wire logic [NUM_FAST_IRQ-1:0] i_fast_external_interrupt_input,
    input wire logic [NUM_FAST_IRQ-1:0] i_fast_irq_enable,
    input wire logic [NUM_FAST_IRQ-1:0] i_fast_irq_active_high,
    input wire logic i_rtc_irq,
    input wire logic i_rtc_enable,
    input wire logic i_chip_reset,
    input wire logic i_standby_ram_enable_bit,
    input wire prm_pkg::prm_clk_ctl_s o_clk_ctl,
    input wire prm_pkg::prm_ram_ctl_s o_ram_ctl,
    input wire prm_pkg::prm_state_e o_state,
    input wire logic o_entry_refused
);
    // Some enabled fast line sits at its active level
    logic fast_act;
    // Either power-down state
    logic pd_now;
    // Entry request taken while running
    logic req_run;
    assign fast_act = |(i_fast_irq_enable &
        ~(i_fast_external_interrupt_input ^ i_fast_irq_active_high));
    assign pd_now = o_state == prm_pkg::PRM_PD_PROT || o_state == prm_pkg::PRM_PD_INT;
    assign req_run = o_state == prm_pkg::PRM_RUN && (i_idle_instruction || i_power_down_instruction);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_idle_clocks: assert property (
        o_state == prm_pkg::PRM_IDLE |-> o_clk_ctl.cpu_halt && o_clk_ctl.periph_clk_en)
        else $error("idle clock controls wrong");
    a_pd_stopped: assert property (
        pd_now |-> o_clk_ctl.cpu_halt && !o_clk_ctl.periph_clk_en)
        else $error("power-down clock controls wrong");
    a_drain_holds: assert property (
        o_state == prm_pkg::PRM_DRAIN && i_bus_busy |=> o_state == prm_pkg::PRM_DRAIN)
        else $error("left drain with bus busy");
    a_ready_refuse: assert property (
        req_run && i_ready_enable && !i_ready_seen
        |=> o_entry_refused && o_state == prm_pkg::PRM_RUN)
        else $error("missed handshake not refused");
    a_idle_wake: assert property (
        o_state == prm_pkg::PRM_IDLE && i_irq_request |-> ##[1:6] o_state == prm_pkg::PRM_RUN)
        else $error("idle not ended by interrupt");
    a_lp_main_off: assert property (
        pd_now && o_clk_ctl.rtc_ref_lp |-> !o_clk_ctl.main_osc_en)
        else $error("main oscillator kept with low-power reference");
    a_main_kept: assert property (
        pd_now && i_rtc_enable && !o_clk_ctl.rtc_ref_lp |-> o_clk_ctl.main_osc_en)
        else $error("main oscillator stopped while referencing clock");
    a_nmi_refuse: assert property (
        req_run && i_power_down_instruction && !i_system_configuration_register[5] && i_nmi_n
        && !(i_ready_enable && !i_ready_seen) |=> o_entry_refused)
        else $error("protected entry with nmi high");
    a_prot_sticky: assert property (
        o_state == prm_pkg::PRM_PD_PROT |=> o_state == prm_pkg::PRM_PD_PROT)
        else $error("protected power-down left without reset");
    a_fast_refuse: assert property (
        req_run && i_power_down_instruction && i_system_configuration_register[5] && fast_act
        && $past(fast_act) && $past(fast_act, 2) && $past(fast_act, 3) |=> o_entry_refused)
        else $error("interruptible entry with active fast line");
    a_rtc_wake: assert property (
        o_state == prm_pkg::PRM_PD_INT && i_rtc_irq |-> ##[1:8] o_state == prm_pkg::PRM_RUN)
        else $error("clock interrupt did not wake");
    a_standby_frz: assert property (
        i_chip_reset && !i_standby_ram_enable_bit |-> o_ram_ctl.ram_freeze)
        else $error("standby ram not frozen");
endmodule : prm_ctrl_asserts

bind prm_ctrl prm_ctrl_asserts #(.NUM_FAST_IRQ(NUM_FAST_IRQ)) u_asserts (.i_clk, .i_rst_n,
    .i_idle_instruction, .i_power_down_instruction, .i_system_configuration_register,
    .i_bus_busy, .i_ready_enable, .i_ready_seen, .i_nmi_n, .i_irq_request,
    .i_fast_external_interrupt_input, .i_fast_irq_enable, .i_fast_irq_active_high, .i_rtc_irq,
    .i_rtc_enable, .i_chip_reset, .i_standby_ram_enable_bit, .o_clk_ctl, .o_ram_ctl, .o_state,
    .o_entry_refused);

// ---- verification/prm_cpu_model.sv ----
// Purpose: Core and fast-interrupt source model facing the controller
// Assumes: Commands from the bench, one per call
// Notes: Fast lines idle at 0, active high
`timescale 1ns/1ns
module prm_cpu_model (
    input wire logic i_clk,
    input wire logic [1:0] i_cmd,
    input wire logic [7:0] i_wake,
    input wire logic [7:0] i_hold,
    output logic o_idle,
    output logic o_pd,
    output logic o_reg_off,
    output logic [7:0] o_fast
);
    // Pending power-down after regulator bit set
    logic pend = 1'b0;
    // Stretch counter and mask for wake pulses
    int cnt = 0;
    logic [7:0] msk = 8'h00;
    initial {o_idle, o_pd, o_reg_off} = 3'h0;
    assign o_fast = i_hold | (cnt > 0 ? msk : 8'h00);
    // Issue instructions; regulator bit goes up one edge ahead of power-down
    always @(posedge i_clk) begin
        o_idle <= i_cmd == 2'h1;
        o_pd <= pend;
        pend <= i_cmd == 2'h2;
        if (i_cmd == 2'h2) begin
            o_reg_off <= 1'b1;
        end
        // Wake lines held 8 cycles, twice the minimum width
        if (i_wake != 8'h00) begin
            msk <= i_wake;
            cnt <= 8;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : prm_cpu_model

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the power reduction mode controller
// Assumes: 100 MHz clock, bench drives on rising edges
// Notes: Standby, idle, refusals, both power-down kinds, all wakes
`timescale 1ns/1ns
module tb_top;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_bus_busy = 1'b0, i_ready_enable = 1'b0;
    logic i_ready_seen = 1'b0, i_nmi_n = 1'b1, i_irq_request = 1'b0, i_return_from_interrupt_done = 1'b0;
    logic i_rtc_irq = 1'b0, i_can_wake = 1'b0, i_i2c_wake = 1'b0, i_rtc_enable = 1'b0;
    logic i_lp_osc_running = 1'b0, i_lp_osc_disable = 1'b0, i_chip_reset = 1'b0;
    logic i_standby_ram_enable_bit = 1'b0, i_core_supply_low = 1'b0;
    logic [15:0] i_system_configuration_register = 16'h0000;
    logic [7:0] i_fast_irq_enable = 8'hff, i_fast_irq_active_high = 8'hff;
    logic [7:0] wake = 8'h00, hold = 8'h00, i_fast_external_interrupt_input;
    logic [1:0] cmd = 2'h0;
    logic i_idle_instruction, i_power_down_instruction, i_main_regulator_off_bit;
    logic o_entry_refused, o_resume_after_idle, o_regulator_off_req, rs;
    prm_pkg::prm_clk_ctl_s o_clk_ctl;
    prm_pkg::prm_ram_ctl_s o_ram_ctl;
    prm_pkg::prm_state_e o_state;
    int error_cnt = 0, num_checks = 0;
    always #5 i_clk = ~i_clk;
    prm_ctrl u_dut (.i_clk, .i_rst_n, .i_idle_instruction, .i_power_down_instruction,
        .i_system_configuration_register, .i_main_regulator_off_bit, .i_bus_busy,
        .i_ready_enable, .i_ready_seen, .i_nmi_n, .i_irq_request, .i_return_from_interrupt_done,
        .i_fast_external_interrupt_input, .i_fast_irq_enable, .i_fast_irq_active_high,
        .i_rtc_irq, .i_can_wake, .i_i2c_wake, .i_rtc_enable, .i_lp_osc_running,
        .i_lp_osc_disable, .i_chip_reset, .i_standby_ram_enable_bit, .i_core_supply_low,
        .o_clk_ctl, .o_ram_ctl, .o_state, .o_entry_refused, .o_resume_after_idle,
        .o_regulator_off_req);
    prm_cpu_model u_cpu (.i_clk, .i_cmd(cmd), .i_wake(wake), .i_hold(hold),
        .o_idle(i_idle_instruction), .o_pd(i_power_down_instruction),
        .o_reg_off(i_main_regulator_off_bit), .o_fast(i_fast_external_interrupt_input));
    // Print counts and verdict, then stop
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // Compare one value
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Wait a few edges, then sample settled outputs
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc
    // Issue one instruction through the core model
    task automatic req(input logic [1:0] k);
        @(posedge i_clk) cmd <= k;
        @(posedge i_clk) cmd <= 2'h0;
    endtask : req
    // Bounded wait for a state, with or without a refusal pulse
    task automatic wt(input prm_pkg::prm_state_e exp, input logic rx);
        logic rf;
        int i;
        rf = 1'b0;
        for (i = 0; i < 40; i++) begin
            cyc(1);
            rf |= o_entry_refused;
            rs |= o_resume_after_idle;
            if (o_state === exp && rf === rx) break;
        end
        num_checks++;
        if (i == 40) begin
            error_cnt++;
            $display("Error at %0t: state %h expected %h", $time, o_state, exp);
            conclude();
        end
    endtask : wt
    initial begin
        cyc(12);
        i_rst_n <= 1'b1;
        cyc(3);
        chk(o_state, prm_pkg::PRM_RUN);
        chk(o_ram_ctl.ram_freeze, 1'b1);
        // Standby entry and exit of the RAM interface
        @(posedge i_clk) i_chip_reset <= 1'b1;
        cyc(2);
        chk(o_ram_ctl.ram_freeze, 1'b1);
        @(posedge i_clk) i_chip_reset <= 1'b0;
        cyc(3);
        chk(o_ram_ctl, 2'h2);
        @(posedge i_clk) i_standby_ram_enable_bit <= 1'b1;
        cyc(3);
        chk(o_ram_ctl.ram_freeze, 1'b0);
        @(posedge i_clk) i_core_supply_low <= 1'b1;
        cyc(3);
        chk(o_ram_ctl.ram_freeze, 1'b1);
        @(posedge i_clk) i_core_supply_low <= 1'b0;
        cyc(3);
        chk(o_ram_ctl.ram_freeze, 1'b0);
        // Idle behind a busy bus, then interrupt wake
        @(posedge i_clk) i_bus_busy <= 1'b1;
        req(2'h1);
        wt(prm_pkg::PRM_DRAIN, 1'b0);
        cyc(3);
        chk(o_state, prm_pkg::PRM_DRAIN);
        @(posedge i_clk) i_bus_busy <= 1'b0;
        wt(prm_pkg::PRM_IDLE, 1'b0);
        chk({o_clk_ctl.cpu_halt, o_clk_ctl.periph_clk_en}, 2'h3);
        rs = 1'b0;
        @(posedge i_clk) i_irq_request <= 1'b1;
        wt(prm_pkg::PRM_RUN, 1'b0);
        chk(rs, 1'b1);
        @(posedge i_clk) begin
            i_irq_request <= 1'b0;
            i_ready_enable <= 1'b1;
        end
        // Missed wait handshake refuses entry
        req(2'h1);
        wt(prm_pkg::PRM_RUN, 1'b1);
        @(posedge i_clk) begin
            i_ready_enable <= 1'b0;
            i_rtc_enable <= 1'b1;
        end
        // Protected power-down: nmi high refuses, nmi low enters
        req(2'h2);
        wt(prm_pkg::PRM_RUN, 1'b1);
        @(posedge i_clk) i_nmi_n <= 1'b0;
        req(2'h2);
        wt(prm_pkg::PRM_PD_PROT, 1'b0);
        chk(o_clk_ctl, 5'h16);
        @(posedge i_clk) begin
            i_rtc_irq <= 1'b1;
            i_irq_request <= 1'b1;
            wake <= 8'h01;
        end
        @(posedge i_clk) wake <= 8'h00;
        cyc(20);
        chk(o_state, prm_pkg::PRM_PD_PROT);
        @(posedge i_clk) {i_rtc_irq, i_irq_request, i_rst_n, i_nmi_n} <= 4'h1;
        cyc(2);
        @(posedge i_clk) {i_rst_n, i_lp_osc_running} <= 2'h3;
        cyc(12);
        chk(o_state, prm_pkg::PRM_RUN);
        chk(o_clk_ctl.rtc_ref_lp, 1'b1);
        // Interruptible power-down: active enabled line refuses
        @(posedge i_clk) begin
            i_system_configuration_register <= 16'h0020;
            hold <= 8'h04;
        end
        cyc(4);
        req(2'h2);
        wt(prm_pkg::PRM_RUN, 1'b1);
        @(posedge i_clk) i_fast_irq_enable <= 8'hfb;
        req(2'h2);
        wt(prm_pkg::PRM_PD_INT, 1'b0);
        chk({o_clk_ctl.main_osc_en, o_clk_ctl.rtc_run}, 2'h1);
        chk(o_regulator_off_req, 1'b1);
        @(posedge i_clk) {hold, i_fast_irq_enable} <= 16'h00ff;
        // Fast line, RTC, CAN and I2C each end interruptible power-down
        for (int s = 0; s < 4; s++) begin
            if (s > 0) begin
                req(2'h2);
                wt(prm_pkg::PRM_PD_INT, 1'b0);
            end
            @(posedge i_clk) begin
                wake <= (s == 0) ? 8'h80 : 8'h00;
                {i_rtc_irq, i_can_wake, i_i2c_wake} <= 3'h4 >> (s - 1);
            end
            @(posedge i_clk) wake <= 8'h00;
            wt(prm_pkg::PRM_RUN, 1'b0);
            @(posedge i_clk) {i_rtc_irq, i_can_wake, i_i2c_wake} <= 3'h0;
            cyc(12);
        end
        conclude();
    end
endmodule : tb_top
